/* hdl/ifv_pkg.sv */
// Purpose: constants and carriers of the interrupt flag and vector block
// Assumes: 8-bit registers, one aligned 32-bit APB word each
// Notes:   flags sit in the high nibble, enables in the low nibble
package ifv_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] OFF_CTRL3  = 4'h0;
  localparam logic [3:0] OFF_SHVEC  = 4'h4;
  localparam logic [3:0] OFF_GLOBAL = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] RST_CTRL3   = 8'h00;
  localparam logic [7:0] RST_SHVEC   = 8'h00;
  localparam logic [7:0] SHV_SMALL_M = 8'h33;
  localparam int         FLAG_LSB    = 4;
  localparam int         EN_LSB      = 0;
  localparam int         GLB_GIE     = 0;
  localparam int         GLB_SVF     = 1;
  localparam int         GLB_SVE     = 2;
  localparam int         STA_FULL    = 7;

  // ==========================================================
  // Vectors, index order is priority order
  localparam int         NSRC        = 5;
  localparam logic [11:0] VEC_SHARED = 12'h014;
  localparam logic [11:0] VEC_TICK0  = 12'h018;
  localparam logic [11:0] VEC_TICK1  = 12'h01C;
  localparam logic [11:0] VEC_CONV   = 12'h020;
  localparam logic [11:0] VEC_LOWV   = 12'h024;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic tick1;
    logic tick0;
    logic conv_done;
    logic lowvolt;
    logic compact2_cmpa;
    logic compact2_cmpp;
    logic periodic2_cmpa;
    logic periodic2_cmpp;
  } ifv_evt_t;

  typedef struct packed {
    logic call;
    logic ret;
    logic int_ret;
    logic boundary;
    logic sleep;
  } ifv_core_t;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_ANS  = 1'b1
  } ifv_ph_t;

endpackage

/* hdl/ifv_top.sv */
// Purpose: interrupt flags, gating, priority and vectoring with stack
// Assumes: core raises boundary on cycles where it may be interrupted
// Notes:   one wait state on every APB access; all state frozen by ce
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module ifv_top #(
  parameter int unsigned PC_W        = 12,
  parameter int unsigned STACK_DEPTH = 6,
  parameter bit          LARGE_SHV   = 1'b1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [3:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire ifv_pkg::ifv_evt_t  evt,
  input  wire ifv_pkg::ifv_core_t core,
  input  wire logic [PC_W-1:0]  core_next_pc,
  output logic                  pc_load,
  output logic      [PC_W-1:0]  pc_target,
  output logic                  int_ack,
  output logic      [2:0]       int_src,
  output logic                  wake
);

  // ==========================================================
  // Local types and state
  localparam int unsigned SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [7:0]  SHV_M = LARGE_SHV ? 8'hFF
                                            : ifv_pkg::SHV_SMALL_M;

  typedef struct packed {
    ifv_pkg::ifv_ph_t                    ph;
    logic [31:0]                         rdata;
    logic                                slverr;
    logic [7:0]                          ctrl3;
    logic [7:0]                          shv;
    logic                                gie;
    logic                                svf;
    logic                                sve;
    logic [3:0]                          sv_prev;
    logic [SP_W-1:0]                     sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0]    stk;
    logic                                pc_load;
    logic [PC_W-1:0]                     pc_target;
    logic                                int_ack;
    logic [2:0]                          int_src;
    logic                                wake;
  } ifv_state_t;

  ifv_state_t st_r;
  ifv_state_t st_nxt;

  // ==========================================================
  // Decoding helpers
  function automatic logic [2:0] reg_sel(input logic [3:0] a);
    logic [2:0] s;
    s = 3'h0;
    if (a == ifv_pkg::OFF_CTRL3) begin
      s = 3'h1;
    end else if (a == ifv_pkg::OFF_SHVEC) begin
      s = 3'h2;
    end else if (a == ifv_pkg::OFF_GLOBAL) begin
      s = 3'h3;
    end else if (a == ifv_pkg::OFF_STATUS) begin
      s = 3'h4;
    end
    return s;
  endfunction

  // Lowest index wins, indices follow ascending vector address
  function automatic logic [2:0] pick(input logic [4:0] p);
    logic [2:0] k;
    k = 3'h0;
    for (int i = ifv_pkg::NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  function automatic logic [11:0] vec_of(input logic [2:0] k);
    logic [11:0] v;
    case (k)
      3'h0:    v = ifv_pkg::VEC_SHARED;
      3'h1:    v = ifv_pkg::VEC_TICK0;
      3'h2:    v = ifv_pkg::VEC_TICK1;
      3'h3:    v = ifv_pkg::VEC_CONV;
      default: v = ifv_pkg::VEC_LOWV;
    endcase
    return v;
  endfunction

  // Flag bit of an individual source in the control register
  function automatic logic [7:0] clr_of(input logic [2:0] k);
    logic [7:0] m;
    case (k)
      3'h1:    m = 8'h40;
      3'h2:    m = 8'h80;
      3'h3:    m = 8'h20;
      3'h4:    m = 8'h10;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Request gating
  logic [3:0]  req3;
  logic [7:0]  shv_vis;
  logic [3:0]  reqsv;
  logic [4:0]  pend;
  logic        full;
  logic        core_busy;
  logic        take;
  logic [2:0]  src;

  always_comb begin
    req3    = st_r.ctrl3[ifv_pkg::FLAG_LSB +: 4]
            & st_r.ctrl3[ifv_pkg::EN_LSB +: 4];
    shv_vis = st_r.shv & SHV_M;
    reqsv   = shv_vis[ifv_pkg::FLAG_LSB +: 4]
            & shv_vis[ifv_pkg::EN_LSB +: 4];
    pend    = {req3[0], req3[1], req3[3], req3[2],
               st_r.svf & st_r.sve};
    full    = (st_r.sp == SP_W'(STACK_DEPTH));
    core_busy = core.call | core.ret | core.int_ret;
    take    = st_r.gie & ~full & ~core_busy
            & core.boundary & (|pend);
    src     = pick(pend);
  end

  // ==========================================================
  // Next state
  logic        acc;
  logic        wr;
  logic [2:0]  sel;
  logic [7:0]  wb;
  logic [7:0]  set3;
  logic [7:0]  setsv;
  logic        svf_set;
  logic [9:0]  old_f;
  logic [9:0]  new_f;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.int_ack = 1'b0;
    acc = psel & penable;
    sel = reg_sel(paddr);
    wb  = pwdata[7:0];
    wr  = acc & (st_r.ph == ifv_pkg::PH_ANS) & pwrite & pstrb[0];

    // APB: answer one cycle into the access phase
    case (st_r.ph)
      ifv_pkg::PH_IDLE: begin
        if (acc) begin
          st_nxt.ph     = ifv_pkg::PH_ANS;
          st_nxt.slverr = (sel == 3'h0);
          st_nxt.rdata  = 32'h0000_0000;
          if (!pwrite) begin
            if (sel == 3'h1) begin
              st_nxt.rdata[7:0] = st_r.ctrl3;
            end else if (sel == 3'h2) begin
              st_nxt.rdata[7:0] = shv_vis;
            end else if (sel == 3'h3) begin
              st_nxt.rdata[ifv_pkg::GLB_GIE] = st_r.gie;
              st_nxt.rdata[ifv_pkg::GLB_SVF] = st_r.svf;
              st_nxt.rdata[ifv_pkg::GLB_SVE] = st_r.sve;
            end else if (sel == 3'h4) begin
              st_nxt.rdata[SP_W-1:0]          = st_r.sp;
              st_nxt.rdata[ifv_pkg::STA_FULL] = full;
            end
          end
        end
      end
      default: begin
        st_nxt.ph     = ifv_pkg::PH_IDLE;
        st_nxt.slverr = 1'b0;
        st_nxt.rdata  = 32'h0000_0000;
      end
    endcase

    // Software writes; a one on a flag counts as an event
    if (wr) begin
      if (sel == 3'h1) begin
        st_nxt.ctrl3 = wb;
      end else if (sel == 3'h2) begin
        st_nxt.shv = wb & SHV_M;
      end else if (sel == 3'h3) begin
        st_nxt.gie = wb[ifv_pkg::GLB_GIE];
        st_nxt.svf = wb[ifv_pkg::GLB_SVF];
        st_nxt.sve = wb[ifv_pkg::GLB_SVE];
      end
    end

    // Return paths; ret and int_ret share the stack
    if (core.ret | core.int_ret) begin
      if (st_r.sp != '0) begin
        st_nxt.sp        = st_r.sp - SP_W'(1);
        st_nxt.pc_target = st_r.stk[st_r.sp - SP_W'(1)];
        st_nxt.pc_load   = 1'b1;
      end
      if (core.int_ret) begin
        st_nxt.gie = 1'b1;
      end
    end else if (core.call && !full) begin
      st_nxt.stk[st_r.sp] = core_next_pc;
      st_nxt.sp           = st_r.sp + SP_W'(1);
    end

    // Acceptance
    if (take) begin
      st_nxt.stk[st_r.sp] = core_next_pc;
      st_nxt.sp           = st_r.sp + SP_W'(1);
      st_nxt.pc_target    = PC_W'(vec_of(src));
      st_nxt.pc_load      = 1'b1;
      st_nxt.int_ack      = 1'b1;
      st_nxt.int_src      = src;
      st_nxt.gie          = 1'b0;
      if (src == 3'h0) begin
        st_nxt.svf = 1'b0;
      end else begin
        st_nxt.ctrl3 = st_nxt.ctrl3 & ~clr_of(src);
      end
    end

    // Hardware sets last so they beat any clear
    set3  = {evt.tick1, evt.tick0, evt.conv_done, evt.lowvolt,
             4'h0};
    setsv = {evt.compact2_cmpa, evt.compact2_cmpp,
             evt.periodic2_cmpa, evt.periodic2_cmpp, 4'h0} & SHV_M;
    st_nxt.ctrl3 = st_nxt.ctrl3 | set3;
    st_nxt.shv   = st_nxt.shv | setsv;
    // New member request re-arms the shared flag
    svf_set        = |(reqsv & ~st_r.sv_prev);
    st_nxt.svf     = st_nxt.svf | svf_set;
    st_nxt.sv_prev = reqsv;

    // Only a fresh flag wakes, so a preset one stays quiet
    old_f = {st_r.ctrl3[7:4], shv_vis[7:4], st_r.svf, 1'b0};
    new_f = {st_nxt.ctrl3[7:4], st_nxt.shv[7:4], st_nxt.svf, 1'b0};
    st_nxt.wake = core.sleep & (|(new_f & ~old_f));
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.ph        <= ifv_pkg::PH_IDLE;
      st_r.ctrl3     <= ifv_pkg::RST_CTRL3;
      st_r.shv       <= ifv_pkg::RST_SHVEC;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from state
  assign prdata    = st_r.rdata;
  assign pready    = st_r.ph;
  assign pslverr   = st_r.slverr;
  assign pc_load   = st_r.pc_load;
  assign pc_target = st_r.pc_target;
  assign int_ack   = st_r.int_ack;
  assign int_src   = st_r.int_src;
  assign wake      = st_r.wake;

endmodule

`default_nettype wire

/* tb/ifv_core_model.sv */
// Purpose: core fetch and stack side facing ifv_top
// Assumes: bench pulses call, ret and return_from_interrupt in cmd
// Notes:   pc frozen between loads so pushed values are known
`timescale 1ns/10ps
`default_nettype none
module ifv_core_model #(
  parameter int unsigned PC_W = 12,
  parameter logic [11:0] PC0  = 12'h3A5
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [2:0]         cmd,
  input  wire logic               busy,
  input  wire logic               sleep,
  input  wire logic               pc_load,
  input  wire logic [PC_W-1:0]    pc_target,
  output var ifv_pkg::ifv_core_t  core,
  output logic [PC_W-1:0]         core_next_pc
);
  // ==========
  // Fetch
  logic [PC_W-1:0] pc_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc_r <= PC_W'(PC0);
    else if (pc_load) pc_r <= pc_target;
  end
  assign core_next_pc = pc_r;
  // Busy stretches the wait for a boundary, the slow answer
  // No boundary while a load is pending: the pc is still the old one
  assign core = '{call: cmd[2], ret: cmd[1], int_ret: cmd[0],
                  boundary: !busy && !pc_load, sleep: sleep};
endmodule
`default_nettype wire

/* tb/ifv_top_asserts.sv */
// Purpose: port checker for ifv_top
// Assumes: ce held high, core model never calls into a full stack
// Notes:   depth count lags the core by one edge on interrupts and on returns
`timescale 1ns/10ps
`default_nettype none
module ifv_top_chk #(
  parameter int unsigned PC_W        = 12,
  parameter int unsigned STACK_DEPTH = 6
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               ce,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire ifv_pkg::ifv_core_t core,
  input wire logic               pc_load,
  input wire logic [PC_W-1:0]    pc_target,
  input wire logic               int_ack,
  input wire logic [2:0]         int_src,
  input wire logic               wake
);
  // ==========
  // Helpers
  logic [3:0] dep_r;
  logic [3:0] dep_nxt;
  function automatic logic [11:0] vec_of(input logic [2:0] s);
    case (s)
      3'h0: vec_of = ifv_pkg::VEC_SHARED;
      3'h1: vec_of = ifv_pkg::VEC_TICK0;
      3'h2: vec_of = ifv_pkg::VEC_TICK1;
      3'h3: vec_of = ifv_pkg::VEC_CONV;
      3'h4: vec_of = ifv_pkg::VEC_LOWV;
      default: vec_of = 12'hFFF;
    endcase
  endfunction
  always_comb begin
    dep_nxt = dep_r + 4'(core.call) + 4'(int_ack) - 4'(pc_load && !int_ack);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dep_r <= 4'h0;
    else dep_r <= dep_nxt;
  end
  // ==========
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready missing after access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_ack_vector: assert property (
    int_ack |-> pc_load && pc_target == PC_W'(vec_of(int_src)))
    else $error("vector does not match source");
  a_ack_cause: assert property (
    int_ack |-> $past(core.boundary)
      && !$past(core.int_ret || core.ret || core.call))
    else $error("accept outside a boundary");
  a_no_nest: assert property (int_ack |=> !int_ack [*2])
    else $error("nested accept");
  a_full_block: assert property (int_ack |-> dep_r < 4'(STACK_DEPTH))
    else $error("accept with full stack");
  a_target_hold: assert property (
    !pc_load |-> $stable(pc_target) && $stable(int_src))
    else $error("target moved without load");
  a_wake_cause: assert property (wake |-> $past(core.sleep))
    else $error("wake while awake");
  c_shared: cover property (int_ack && int_src == 3'h0);
  c_pop: cover property (pc_load && !int_ack);
  c_wake: cover property (wake);
endmodule
bind ifv_top ifv_top_chk #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) ifv_top_chk_i (
  .pclk, .presetn, .ce, .psel, .penable, .prdata, .pready, .core,
  .pc_load, .pc_target, .int_ack, .int_src, .wake);
`default_nettype wire

/* tb/ifv_top_tb_top.sv */
// Purpose: register and vectoring tests of ifv_top
// Assumes: default parameters, large and small shared register copies
// Notes:   ce and pstrb tied high
`timescale 1ns/10ps
`default_nettype none
module ifv_top_tb_top;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [3:0]         paddr = 4'h0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready, pslverr, pc_load, int_ack, wake, er;
  logic [11:0]        pc_target, core_next_pc;
  logic [2:0]         int_src;
  logic [2:0]         cmd = 3'h0;
  logic               busy = 1'b0;
  logic               sleep = 1'b0;
  logic [7:0]         rd;
  logic [7:0]         rds;
  logic [31:0]        prdata_s;
  ifv_pkg::ifv_evt_t  evt = '0;
  ifv_pkg::ifv_core_t core;
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 n_wake = 0;
  localparam logic [11:0] PC0 = 12'h3A5;
  logic [11:0] vec [5] = '{ifv_pkg::VEC_SHARED, ifv_pkg::VEC_TICK0,
    ifv_pkg::VEC_TICK1, ifv_pkg::VEC_CONV, ifv_pkg::VEC_LOWV};
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (wake === 1'b1) n_wake++;
  ifv_top ifv_top_i (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .evt, .core,
    .core_next_pc, .pc_load, .pc_target, .int_ack, .int_src, .wake);
  // Small variant shares the bus, only its read data is watched
  ifv_top #(.LARGE_SHV(1'b0)) ifv_top_small_i (.pclk, .presetn, .ce(1'b1),
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata(prdata_s), .pready(), .pslverr(), .evt, .core, .core_next_pc,
    .pc_load(), .pc_target(), .int_ack(), .int_src(), .wake());
  ifv_core_model #(.PC0(PC0)) ifv_core_model_i (.pclk, .presetn, .cmd,
    .busy, .sleep, .pc_load, .pc_target, .core, .core_next_pc);
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata[7:0];
    rds = prdata_s[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk("pready", 1, k < 20);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic exp_load(input logic a, input logic [2:0] s,
                          input logic [11:0] t);
    int k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pc_load !== 1'b1 && k < 30);
    chk("pc_load", 1, pc_load);
    chk("int_ack", a, int_ack);
    chk("pc_target", t, pc_target);
    if (a) chk("int_src", s, int_src);
  endtask
  task automatic quiet(input int c);
    logic h = 1'b0;
    repeat (c) begin
      @(posedge pclk);
      if (pc_load === 1'b1) h = 1'b1;
    end
    chk("no load", 0, h);
  endtask
  task automatic cm(input logic [2:0] c);
    cmd <= c;
    @(posedge pclk);
    cmd <= 3'h0;
  endtask
  task automatic ev(input ifv_pkg::ifv_evt_t e);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========
  // Tests
  // Whole sequence needs some 215 cycles, the limit leaves ample slack
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("ctrl3", ifv_pkg::OFF_CTRL3, 8'h00);
    rchk("shvec", ifv_pkg::OFF_SHVEC, 8'h00);
    apb(1'b0, 4'h2, 8'h00);
    chk("unmapped", 1, er);
    apb(1'b1, ifv_pkg::OFF_CTRL3, 8'hFF);
    rchk("ctrl3", ifv_pkg::OFF_CTRL3, 8'hFF);
    apb(1'b1, ifv_pkg::OFF_SHVEC, 8'hFF);
    rchk("shvec", ifv_pkg::OFF_SHVEC, 8'hFF);
    chk("shvec small", 8'h33, rds);
    rchk("global", ifv_pkg::OFF_GLOBAL, 8'h02);
    apb(1'b1, ifv_pkg::OFF_CTRL3, 8'h00);
    apb(1'b1, ifv_pkg::OFF_SHVEC, 8'h00);
    apb(1'b1, ifv_pkg::OFF_GLOBAL, 8'h01);
    ev('{conv_done: 1'b1, default: 1'b0});
    quiet(8);
    rchk("ctrl3", ifv_pkg::OFF_CTRL3, 8'h20);
    busy <= 1'b1;
    apb(1'b1, ifv_pkg::OFF_CTRL3, 8'h22);
    quiet(6);
    busy <= 1'b0;
    exp_load(1'b1, 3'h3, ifv_pkg::VEC_CONV);
    rchk("global", ifv_pkg::OFF_GLOBAL, 8'h00);
    rchk("ctrl3", ifv_pkg::OFF_CTRL3, 8'h02);
    apb(1'b1, ifv_pkg::OFF_CTRL3, 8'h0A);
    ev('{tick1: 1'b1, default: 1'b0});
    quiet(8);
    rchk("ctrl3", ifv_pkg::OFF_CTRL3, 8'h8A);
    cm(3'h1);
    exp_load(1'b0, 3'h0, PC0);
    exp_load(1'b1, 3'h2, ifv_pkg::VEC_TICK1);
    cm(3'h1);
    exp_load(1'b0, 3'h0, PC0);
    apb(1'b1, ifv_pkg::OFF_GLOBAL, 8'h04);
    apb(1'b1, ifv_pkg::OFF_SHVEC, 8'h22);
    apb(1'b1, ifv_pkg::OFF_CTRL3, 8'hFF);
    apb(1'b1, ifv_pkg::OFF_GLOBAL, 8'h07);
    for (int i = 0; i < 5; i++) begin
      exp_load(1'b1, 3'(i), vec[i]);
      cm(3'h1);
      exp_load(1'b0, 3'h0, PC0);
    end
    rchk("shvec", ifv_pkg::OFF_SHVEC, 8'h22);
    rchk("ctrl3", ifv_pkg::OFF_CTRL3, 8'h0F);
    apb(1'b1, ifv_pkg::OFF_GLOBAL, 8'h04);
    ev('{tick0: 1'b1, tick1: 1'b1, default: 1'b0});
    apb(1'b1, ifv_pkg::OFF_GLOBAL, 8'h05);
    exp_load(1'b1, 3'h1, ifv_pkg::VEC_TICK0);
    apb(1'b1, ifv_pkg::OFF_GLOBAL, 8'h05);
    exp_load(1'b1, 3'h2, ifv_pkg::VEC_TICK1);
    cm(3'h1);
    exp_load(1'b0, 3'h0, ifv_pkg::VEC_TICK0);
    cm(3'h1);
    exp_load(1'b0, 3'h0, PC0);
    for (int i = 0; i < 6; i++) begin
      cm(3'h4);
      @(posedge pclk);
    end
    rchk("status", ifv_pkg::OFF_STATUS, 8'h86);
    ev('{lowvolt: 1'b1, default: 1'b0});
    quiet(8);
    cm(3'h2);
    exp_load(1'b0, 3'h0, PC0);
    exp_load(1'b1, 3'h4, ifv_pkg::VEC_LOWV);
    sleep <= 1'b1;
    ev('{tick0: 1'b1, default: 1'b0});
    repeat (4) @(posedge pclk);
    chk("wake", 1, n_wake);
    ev('{tick0: 1'b1, default: 1'b0});
    repeat (4) @(posedge pclk);
    chk("wake", 1, n_wake);
    complete_run();
  end
endmodule
`default_nettype wire
